// ==== hw/mpp_defs.svh ====
// Purpose: constants for the multi-protocol peripheral port
// Assumes: 100 MHz system clock
// Notes: I2C timing counts derive from rates given in hertz
`ifndef MPP_DEFS_SVH
`define MPP_DEFS_SVH
`define MPP_CLK_HZ 100000000
`define MPP_I2C_HZ_0 20000
`define MPP_I2C_HZ_1 100000
`define MPP_I2C_HZ_2 400000
`define MPP_I2C_HZ_3 750000
// quarter-period counts, rounded down so the bus never runs slow of spec
`define MPP_I2C_Q0 (`MPP_CLK_HZ / (4 * `MPP_I2C_HZ_0))
`define MPP_I2C_Q1 (`MPP_CLK_HZ / (4 * `MPP_I2C_HZ_1))
`define MPP_I2C_Q2 (`MPP_CLK_HZ / (4 * `MPP_I2C_HZ_2))
`define MPP_I2C_Q3 (`MPP_CLK_HZ / (4 * `MPP_I2C_HZ_3))
`define MPP_SPI_HALF 16'h0004
`define MPP_STROBE_MIN 16'h0004
`define MPP_BIT_STREAM_CLK 3
`define MPP_BYTE_RESET 8'h00
`endif

// ==== hw/mpp_pkg.sv ====
// Purpose: types for the multi-protocol peripheral port
// Assumes: nothing beyond the defs header
// Notes: command codes are the host-facing operations
package mpp_pkg;
  typedef enum logic [3:0] {
    MPP_CMD_PAR_RD_DATA,
    MPP_CMD_PAR_RD_ADDR,
    MPP_CMD_PAR_WR_DATA,
    MPP_CMD_PAR_WR_ADDR,
    MPP_CMD_MEM_RD,
    MPP_CMD_MEM_WR,
    MPP_CMD_I2C,
    MPP_CMD_SPI4,
    MPP_CMD_SPI3,
    MPP_CMD_SPI_DUAL,
    MPP_CMD_BIT_STREAM
  } mpp_cmd_t;
  typedef enum logic [1:0] {
    MPP_I2C_NONE,
    MPP_I2C_START,
    MPP_I2C_STOP
  } mpp_i2c_ev_t;
endpackage : mpp_pkg

// ==== hw/mpp_strobe_if.sv ====
// Purpose: bundle between the port engine and its strobe timer
// Assumes: single clock
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/100ps
interface mpp_strobe_if;
  logic start;
  logic wait_n;
  logic active;
  logic done;
  modport engine (output start, output wait_n, input active, input done);
  modport timer (input start, input wait_n, output active, output done);
endinterface : mpp_strobe_if

// ==== hw/mpp_strobe_timer.sv ====
// Purpose: times one parallel or memory strobe, stretched by wait
// Assumes: wait_n is synchronous to clock_i
// Notes: strobe lasts at least the minimum count, then until wait_n is high
`timescale 1ns/100ps
`include "mpp_defs.svh"
module mpp_strobe_timer
  import mpp_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic enable_i,
  // engine side
  mpp_strobe_if.timer st
);
  typedef struct packed {
    logic active;
    logic done;
    logic [15:0] count;
  } mpp_timer_state_t;
  mpp_timer_state_t state;
  mpp_timer_state_t next_state;

  // count out the minimum, then hold while the peripheral waits
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    if (st.start && !state.active) begin
      next_state.active = 1'b1;
      next_state.count = 16'h0000;
    end else if (state.active) begin
      if (state.count < `MPP_STROBE_MIN - 16'h0001) begin
        next_state.count = state.count + 16'h0001;
      end else if (st.wait_n) begin
        next_state.active = 1'b0;
        next_state.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= '0;
    end else if (enable_i) begin
      state <= next_state;
    end
  end

  assign st.active = state.active;
  assign st.done = state.done;
endmodule : mpp_strobe_timer

// ==== hw/mpp_port.sv ====
// Purpose: peripheral-side engine for parallel, memory, I2C and SPI transfers
// Assumes: inputs synchronous to clock_i; host gives one byte per request
// Notes: pin direction outside transfers is not programmed here
// Function
// - Peripheral mode entered when data line low at init or activity pulled low.
// - Parallel mode moves bytes on 8-bit bus with data or address strobe.
// - Parallel read keeps read/write high and strobes data or address select.
// - Parallel write drives read/write low; address set is a single byte.
// - Peripheral reset output low while the chip is in reset.
// - Memory mode pulses dedicated read strobe or write strobe on 8-bit bus.
// - Memory mode drives one register select line per transfer.
// - Memory read sets register select and asserts read strobe in the same cycle.
// - Memory write sets register select and asserts write strobe in the same cycle.
// - I2C clock at 20, 100, 400 or 750 kHz.
// - I2C engine is always the only master.
// - I2C supports raw stream and register-addressed byte sequences.
// - SPI engine is master only, driving clock and chip selects.
// - SPI is full duplex; each byte out returns one byte in.
// - Four-wire mode 0 shifts out on serial out, samples serial in.
// - Three chip selects; addressed one held for whole four-wire transfer.
// - Four- and three-wire bit order selectable, MSB or LSB first; dual mode is fixed.
// - Three-wire mode drives on rising edge, samples on falling edge.
// - Dual mode: upper nibble on primary pair, lower on secondary pair.
// - Bit stream puts bits 0-2,4,5 on the bus output with every enable low; bits 6,7 capture lines 6,7.
// - Bit stream toggles its clock on bus output bit 3 but leaves line 3 undriven.
`timescale 1ns/100ps
`include "mpp_defs.svh"
module mpp_port
  import mpp_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic enable_i,
  // mode straps
  input wire logic strap_sda_i,
  input wire logic strap_act_i,
  output logic periph_mode_o,
  // host request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [3:0] req_cmd_i,
  input wire logic [7:0] req_data_i,
  input wire logic [1:0] req_sel_i,
  input wire logic req_lsb_first_i,
  input wire logic req_last_i,
  input wire logic [1:0] i2c_rate_i,
  input wire logic [1:0] i2c_event_i,
  input wire logic i2c_read_i,
  // host answer
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_nack_o,
  output logic irq_pending_o,
  input wire logic irq_clear_i,
  // parallel bus
  input wire logic [7:0] parallel_data_bus_i,
  output logic [7:0] parallel_data_bus_o,
  output logic [7:0] parallel_data_bus_oe_o,
  output logic write_n_o,
  output logic data_select_n_o,
  output logic address_select_n_o,
  output logic read_n_o,
  output logic register_select_line_o,
  input wire logic wait_n_i,
  input wire logic int_req_n_i,
  output logic periph_reset_n_o,
  // i2c pins, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  // spi pins
  input wire logic serial_in_i,
  input wire logic serial_in_secondary_i,
  output logic serial_out_o,
  output logic serial_out_secondary_o,
  output logic serial_clock_out_o,
  output logic chip_select_zero_o,
  output logic chip_select_one_o,
  output logic chip_select_two_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_STROBE, ST_I2C, ST_SPI, ST_ANSWER
  } mpp_phase_t;

  typedef struct packed {
    mpp_phase_t phase;
    logic mode;
    logic strap_done;
    logic [3:0] cmd;
    logic [7:0] dout;
    logic [7:0] oe;
    logic wr_n;
    logic ds_n;
    logic as_n;
    logic rd_n;
    logic a0;
    logic [7:0] shift;
    logic [7:0] rx;
    logic [3:0] bits;
    logic [1:0] quarter;
    logic [15:0] tick;
    logic sck;
    logic so;
    logic so2;
    logic [2:0] cs;
    logic lsb;
    logic last;
    logic scl;
    logic sda;
    logic [1:0] i2c_ev;
    logic i2c_rd;
    logic nack;
    logic rsp;
    logic [7:0] rdata;
    logic irq_q;
    logic irq_pend;
  } mpp_state_t;

  mpp_state_t state;
  mpp_state_t next_state;
  mpp_strobe_if st();
  logic [15:0] i2c_quarter;
  logic spi_rise;
  logic spi_fall;

  // strobe timer shares one start pulse for both strobe families
  mpp_strobe_timer u_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(enable_i),
    .st(st)
  );

  // ------
  // rate selection
  // ------
  always_comb begin
    unique case (i2c_rate_i)
      2'd0: i2c_quarter = 16'(`MPP_I2C_Q0);
      2'd1: i2c_quarter = 16'(`MPP_I2C_Q1);
      2'd2: i2c_quarter = 16'(`MPP_I2C_Q2);
      default: i2c_quarter = 16'(`MPP_I2C_Q3);
    endcase
  end

  assign spi_rise = (state.tick == `MPP_SPI_HALF - 16'h0001) && !state.sck;
  assign spi_fall = (state.tick == `MPP_SPI_HALF - 16'h0001) && state.sck;
  assign st.wait_n = wait_n_i;

  // ------
  // next-state logic
  // ------
  always_comb begin
    next_state = state;
    next_state.rsp = 1'b0;
    st.start = 1'b0;
    // mode strap caught once after reset release
    if (!state.strap_done) begin
      next_state.strap_done = 1'b1;
      next_state.mode = !strap_sda_i || !strap_act_i;
    end
    // interrupt edge: set wins over clear
    next_state.irq_q = int_req_n_i;
    if (irq_clear_i) begin
      next_state.irq_pend = 1'b0;
    end
    if (int_req_n_i && !state.irq_q) begin
      next_state.irq_pend = 1'b1;
    end
    unique case (state.phase)
      ST_IDLE: begin
        if (req_valid_i && state.mode && state.strap_done) begin
          next_state.cmd = req_cmd_i;
          next_state.lsb = req_lsb_first_i;
          next_state.last = req_last_i;
          next_state.tick = 16'h0000;
          next_state.quarter = 2'd0;
          next_state.bits = 4'd0;
          next_state.shift = req_data_i;
          next_state.nack = 1'b0;
          unique case (mpp_cmd_t'(req_cmd_i))
            MPP_CMD_PAR_RD_DATA, MPP_CMD_PAR_RD_ADDR: begin
              next_state.wr_n = 1'b1;
              next_state.oe = 8'h00;
              next_state.ds_n = req_cmd_i[0];
              next_state.as_n = !req_cmd_i[0];
              next_state.phase = ST_STROBE;
            end
            MPP_CMD_PAR_WR_DATA, MPP_CMD_PAR_WR_ADDR: begin
              next_state.wr_n = 1'b0;
              next_state.dout = req_data_i;
              next_state.oe = 8'hff;
              next_state.ds_n = req_cmd_i[0];
              next_state.as_n = !req_cmd_i[0];
              next_state.phase = ST_STROBE;
            end
            MPP_CMD_MEM_RD: begin
              next_state.a0 = req_sel_i[0];
              next_state.oe = 8'h00;
              next_state.rd_n = 1'b0;
              next_state.phase = ST_STROBE;
            end
            MPP_CMD_MEM_WR: begin
              next_state.a0 = req_sel_i[0];
              next_state.dout = req_data_i;
              next_state.oe = 8'hff;
              next_state.wr_n = 1'b0;
              next_state.phase = ST_STROBE;
            end
            MPP_CMD_I2C: begin
              next_state.i2c_ev = i2c_event_i;
              next_state.i2c_rd = i2c_read_i;
              next_state.phase = ST_I2C;
            end
            MPP_CMD_SPI4, MPP_CMD_SPI3, MPP_CMD_SPI_DUAL, MPP_CMD_BIT_STREAM: begin
              next_state.cs = ~(3'b001 << req_sel_i);
              next_state.phase = ST_SPI;
              if (mpp_cmd_t'(req_cmd_i) == MPP_CMD_SPI3) begin
                next_state.oe = 8'h80;
              end
              if (mpp_cmd_t'(req_cmd_i) == MPP_CMD_BIT_STREAM) begin
                next_state.oe = 8'h00;
                next_state.cs = 3'b111;
                next_state.dout = req_data_i & 8'h37;
              end
            end
            default: next_state.phase = ST_ANSWER;
          endcase
        end
      end
      ST_STROBE: begin
        st.start = !st.active && (state.tick == 16'h0000);
        next_state.tick = 16'h0001;
        if (st.done) begin
          next_state.rdata = parallel_data_bus_i;
          next_state.ds_n = 1'b1;
          next_state.as_n = 1'b1;
          next_state.rd_n = 1'b1;
          next_state.wr_n = 1'b1;
          next_state.oe = 8'h00;
          next_state.phase = ST_ANSWER;
        end
      end
      ST_I2C: begin
        next_state.tick = state.tick + 16'h0001;
        if (state.tick >= i2c_quarter - 16'h0001) begin
          next_state.tick = 16'h0000;
          next_state.quarter = state.quarter + 2'd1;
          if (mpp_i2c_ev_t'(state.i2c_ev) == MPP_I2C_START) begin
            // sda falls while scl high, then scl falls
            unique case (state.quarter)
              2'd0: begin next_state.sda = 1'b1; next_state.scl = 1'b1; end
              2'd1: next_state.sda = 1'b0;
              2'd2: next_state.scl = 1'b0;
              default: next_state.phase = ST_ANSWER;
            endcase
          end else if (mpp_i2c_ev_t'(state.i2c_ev) == MPP_I2C_STOP) begin
            unique case (state.quarter)
              2'd0: next_state.sda = 1'b0;
              2'd1: next_state.scl = 1'b1;
              2'd2: next_state.sda = 1'b1;
              default: next_state.phase = ST_ANSWER;
            endcase
          end else begin
            // nine bits: eight data then acknowledge
            unique case (state.quarter)
              2'd0: begin
                if (state.bits < 4'd8) begin
                  next_state.sda = state.i2c_rd ? 1'b1 : state.shift[7];
                end else begin
                  next_state.sda = state.i2c_rd ? state.last : 1'b1;
                end
              end
              2'd1: next_state.scl = 1'b1;
              2'd2: begin
                if (state.bits < 4'd8) begin
                  next_state.rx = {state.rx[6:0], sda_i};
                end else begin
                  next_state.nack = sda_i;
                end
              end
              default: begin
                next_state.scl = 1'b0;
                next_state.shift = {state.shift[6:0], 1'b0};
                next_state.bits = state.bits + 4'd1;
                if (state.bits == 4'd8) begin
                  next_state.rdata = state.rx;
                  next_state.phase = ST_ANSWER;
                end
              end
            endcase
          end
        end
      end
      ST_SPI: begin
        next_state.tick = state.tick + 16'h0001;
        if (state.tick == `MPP_SPI_HALF - 16'h0001) begin
          next_state.tick = 16'h0000;
          next_state.sck = !state.sck;
        end
        if (mpp_cmd_t'(state.cmd) == MPP_CMD_BIT_STREAM) begin
          // one byte is one clock pulse on output bit 3
          next_state.dout[`MPP_BIT_STREAM_CLK] = next_state.sck;
          if (spi_fall) begin
            next_state.rdata = {parallel_data_bus_i[7:6], state.dout[5:0] & 6'h37};
            next_state.phase = ST_ANSWER;
          end
        end else if (mpp_cmd_t'(state.cmd) == MPP_CMD_SPI_DUAL) begin
          next_state.so = state.shift[7 - state.bits[1:0]];
          next_state.so2 = state.shift[3 - state.bits[1:0]];
          if (spi_rise) begin
            next_state.rx[7 - state.bits[1:0]] = serial_in_i;
            next_state.rx[3 - state.bits[1:0]] = serial_in_secondary_i;
          end
          if (spi_fall) begin
            next_state.bits = state.bits + 4'd1;
            if (state.bits == 4'd3) begin
              next_state.rdata = state.rx;
              next_state.phase = ST_ANSWER;
            end
          end
        end else begin
          if (mpp_cmd_t'(state.cmd) == MPP_CMD_SPI3) begin
            // three-wire: line 7 driven after rising edge
            if (spi_rise) begin
              next_state.dout[7] = state.lsb ? state.shift[0] : state.shift[7];
            end
            if (spi_fall) begin
              next_state.rx = state.lsb ? {parallel_data_bus_i[7], state.rx[7:1]}
                                        : {state.rx[6:0], parallel_data_bus_i[7]};
            end
          end else begin
            // mode 0: data valid before rising edge, sampled there
            next_state.so = state.lsb ? state.shift[0] : state.shift[7];
            if (spi_rise) begin
              next_state.rx = state.lsb ? {serial_in_i, state.rx[7:1]}
                                        : {state.rx[6:0], serial_in_i};
            end
          end
          if (spi_fall) begin
            next_state.shift = state.lsb ? {1'b0, state.shift[7:1]}
                                         : {state.shift[6:0], 1'b0};
            next_state.bits = state.bits + 4'd1;
            if (state.bits == 4'd7) begin
              next_state.rdata = next_state.rx;
              next_state.phase = ST_ANSWER;
            end
          end
        end
      end
      ST_ANSWER: begin
        next_state.rsp = 1'b1;
        next_state.sck = 1'b0;
        next_state.tick = 16'h0000;
        if (state.last && (mpp_cmd_t'(state.cmd) != MPP_CMD_I2C)) begin
          next_state.cs = 3'b111;
          next_state.oe = 8'h00;
        end
        next_state.phase = ST_IDLE;
      end
      default: next_state.phase = ST_IDLE;
    endcase
  end

  // ------
  // state register
  // ------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= '0;
      state.wr_n <= 1'b1;
      state.ds_n <= 1'b1;
      state.as_n <= 1'b1;
      state.rd_n <= 1'b1;
      state.cs <= 3'b111;
      state.scl <= 1'b1;
      state.sda <= 1'b1;
      state.irq_q <= 1'b1;
      state.dout <= `MPP_BYTE_RESET;
    end else if (enable_i) begin
      state <= next_state;
    end
  end

  // ------
  // outputs
  // ------
  assign req_ready_o = (state.phase == ST_IDLE) && state.mode && state.strap_done;
  assign periph_mode_o = state.mode;
  assign rsp_valid_o = state.rsp;
  assign rsp_data_o = state.rdata;
  assign rsp_nack_o = state.nack;
  assign irq_pending_o = state.irq_pend;
  assign parallel_data_bus_o = state.dout;
  assign parallel_data_bus_oe_o = state.oe;
  assign write_n_o = state.wr_n;
  assign data_select_n_o = state.ds_n;
  assign address_select_n_o = state.as_n;
  assign read_n_o = state.rd_n;
  assign register_select_line_o = state.a0;
  assign periph_reset_n_o = !rst_i;
  // open drain: only ever pull low, never drive high
  assign scl_oe_o = !state.scl;
  assign sda_oe_o = !state.sda;
  assign serial_out_o = state.so;
  assign serial_out_secondary_o = state.so2;
  assign serial_clock_out_o = state.sck;
  assign chip_select_zero_o = state.cs[0];
  assign chip_select_one_o = state.cs[1];
  assign chip_select_two_o = state.cs[2];
endmodule : mpp_port

// ==== verif/mpp_port_asserts.sv ====
// Purpose: pin-level checks of the port engine
// Assumes: bound to mpp_port; the bench holds enable_i high
// Notes: strobe means a read or select strobe is low
`timescale 1ns/100ps
module mpp_port_asserts (
  // clock, reset, host side
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic [3:0] req_cmd_i,
  input wire logic [1:0] req_sel_i,
  input wire logic rsp_valid_o,
  input wire logic irq_pending_o,
  // pins
  input wire logic write_n_o,
  input wire logic data_select_n_o,
  input wire logic address_select_n_o,
  input wire logic read_n_o,
  input wire logic register_select_line_o,
  input wire logic wait_n_i,
  input wire logic int_req_n_i,
  input wire logic periph_reset_n_o,
  input wire logic chip_select_zero_o,
  input wire logic chip_select_one_o,
  input wire logic chip_select_two_o
);
  // write_n_o left out: it is also the parallel direction
  logic strobe;
  assign strobe = !data_select_n_o || !address_select_n_o || !read_n_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_take(logic [3:0] c);
    req_valid_i && req_ready_o && req_cmd_i == c;
  endsequence
  a_reset_pin_low: assert property (disable iff (1'b0) rst_i |-> !periph_reset_n_o)
    else $error("peripheral reset high in reset");
  a_par_read: assert property ((s_take(4'd0) or s_take(4'd1)) |=> write_n_o &&
    data_select_n_o == $past(req_cmd_i[0]) && address_select_n_o != data_select_n_o)
    else $error("parallel read pins wrong");
  a_par_write: assert property ((s_take(4'd2) or s_take(4'd3)) |=> !write_n_o &&
    data_select_n_o == $past(req_cmd_i[0]) && address_select_n_o != data_select_n_o)
    else $error("parallel write pins wrong");
  a_mem_select: assert property ((s_take(4'd4) or s_take(4'd5)) |=>
    register_select_line_o == $past(req_sel_i[0]) ##[0:2] read_n_o != write_n_o)
    else $error("memory select or strobe wrong");
  a_strobe_min: assert property ($rose(strobe) |-> strobe [*4])
    else $error("strobe shorter than four cycles");
  a_wait_stretch: assert property (strobe && !wait_n_i |=> strobe)
    else $error("strobe ended while wait low");
  a_strobe_done: assert property ($fell(strobe) |-> ##[0:1] rsp_valid_o)
    else $error("no answer after strobe");
  a_cs_single: assert property (
    $countones({chip_select_zero_o, chip_select_one_o, chip_select_two_o}) >= 2)
    else $error("two chip selects low");
  a_irq_latch: assert property ($rose(int_req_n_i) |-> ##[1:4] irq_pending_o)
    else $error("interrupt edge not latched");
endmodule : mpp_port_asserts

bind mpp_port mpp_port_asserts u_mpp_port_asserts (.*);

// ==== verif/mpp_periph_model.sv ====
// Purpose: peripheral stand-in on bus and spi pins
// Assumes: port outputs registered on clock_i
// Notes: spi target echoes its input; no i2c target, only pull-ups
`timescale 1ns/100ps
module mpp_periph_model (
  // clock and test controls
  input wire logic clock_i,
  input wire logic [3:0] stretch_i,
  input wire logic [1:0] upper_i,
  // pins from the port
  input wire logic [7:0] bus_out_i,
  input wire logic [7:0] bus_oe_i,
  input wire logic wr_n_i,
  input wire logic ds_n_i,
  input wire logic as_n_i,
  input wire logic rd_n_i,
  input wire logic sel_i,
  input wire logic so_i,
  input wire logic so2_i,
  input wire logic [2:0] cs_n_i,
  // pins to the port
  output logic [7:0] bus_in_o,
  output logic wait_n_o,
  output logic si_o,
  output logic si2_o
);
  logic [7:0] regs [4];
  logic [7:0] last, cnt;
  logic act, rd;
  logic [1:0] idx;
  // data, address, then two memory registers
  assign act = !ds_n_i || !as_n_i || !rd_n_i || !wr_n_i;
  assign rd = act && wr_n_i;
  assign idx = !ds_n_i ? 2'h0 : !as_n_i ? 2'h1 : {1'b1, sel_i};
  assign wait_n_o = !act || cnt >= {4'h0, stretch_i};
  // released lines invert their last level; 6 and 7 belong to the target
  assign bus_in_o = (bus_oe_i & bus_out_i) |
    (~bus_oe_i & (rd ? regs[idx] : {upper_i, ~last[5:0]}));
  // full-duplex echo while selected, wandering level otherwise
  assign si_o = &cs_n_i ? ~last[0] : so_i;
  assign si2_o = &cs_n_i ? ~last[1] : so2_i;
  always_ff @(posedge clock_i) begin
    last <= bus_in_o;
    cnt <= act ? cnt + 8'h01 : 8'h00;
    if (act && !rd && bus_oe_i != 8'h00) begin
      regs[idx] <= bus_out_i;
    end
  end
endmodule : mpp_periph_model

// ==== verif/tb_mpp_port.sv ====
// Purpose: self-checking bench for mpp_port
// Assumes: enable_i held high; fixed seed
// Notes: expected bytes come from the bench's own writes and loopback
`timescale 1ns/100ps
module tb_mpp_port;
  logic clock_i, rst_i, enable_i, strap_sda_i, strap_act_i, periph_mode_o, req_valid_i;
  logic req_ready_o, req_lsb_first_i, req_last_i, i2c_read_i, rsp_valid_o, rsp_nack_o;
  logic irq_pending_o, irq_clear_i, write_n_o, data_select_n_o, address_select_n_o, read_n_o;
  logic register_select_line_o, wait_n_i, int_req_n_i, periph_reset_n_o, scl_i, sda_i;
  logic scl_oe_o, sda_oe_o, serial_in_i, serial_in_secondary_i, serial_out_o;
  logic serial_out_secondary_o, serial_clock_out_o, chip_select_zero_o, chip_select_one_o;
  logic chip_select_two_o;
  logic [3:0] req_cmd_i, stretch;
  logic [7:0] req_data_i, rsp_data_o, parallel_data_bus_i, parallel_data_bus_o, r, d;
  logic [7:0] parallel_data_bus_oe_o;
  logic [1:0] req_sel_i, i2c_rate_i, i2c_event_i, upper;
  int mismatches, samples_checked, seed, n;
  mpp_port u_mpp_port (.*);
  mpp_periph_model u_mpp_periph_model (.clock_i(clock_i), .stretch_i(stretch),
    .upper_i(upper), .bus_out_i(parallel_data_bus_o), .bus_oe_i(parallel_data_bus_oe_o),
    .wr_n_i(write_n_o), .ds_n_i(data_select_n_o), .as_n_i(address_select_n_o),
    .rd_n_i(read_n_o), .sel_i(register_select_line_o), .so_i(serial_out_o),
    .so2_i(serial_out_secondary_o), .cs_n_i({chip_select_two_o, chip_select_one_o,
    chip_select_zero_o}), .bus_in_o(parallel_data_bus_i), .wait_n_o(wait_n_i),
    .si_o(serial_in_i), .si2_o(serial_in_secondary_i));
  // open-drain lines with pull-ups and no target
  assign scl_i = !scl_oe_o;
  assign sda_i = !sda_oe_o;
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function automatic int quarter(input int k);
    int hz[4] = '{20000, 100000, 400000, 750000};
    return 100000000 / (4 * hz[k]);
  endfunction : quarter
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // answer latency with slack
  task automatic span(input string what, input int exp);
    samples_checked++;
    if (n < exp - 4 || n > exp + 4) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, n);
    end
  endtask : span
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // one request held until taken, then a bounded wait for the answer
  task automatic xfer(input logic [3:0] c, input logic [7:0] dd, input logic [1:0] s);
    req_cmd_i = c;
    req_data_i = dd;
    req_sel_i = s;
    req_valid_i = 1'b1;
    n = 0;
    while (req_ready_o !== 1'b1) @(posedge clock_i) #1;
    @(posedge clock_i);
    #1 req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 20000) begin
      @(posedge clock_i);
      #1 n++;
    end
    r = rsp_data_o;
    if (n >= 20000) begin
      mismatches++;
      results();
    end
  endtask : xfer
  // about 20k cycles expected
  initial begin
    #500_000;
    mismatches++;
    results();
  end
  initial begin
    seed = 32'h5dca;
    {rst_i, enable_i, strap_sda_i, strap_act_i, req_last_i, int_req_n_i} = 6'h3f;
    {req_valid_i, req_lsb_first_i, i2c_read_i, irq_clear_i, stretch, upper} = 12'h000;
    {req_cmd_i, req_data_i, req_sel_i, i2c_rate_i, i2c_event_i} = 18'h0_0000;
    repeat (2) @(posedge clock_i);
    #1 chk("reset pin", 8'h00, {7'h00, periph_reset_n_o});
    // every strap pattern, ending in peripheral mode
    for (int k = 3; k >= 0; k--) begin
      rst_i = 1'b0;
      repeat (3) @(posedge clock_i);
      #1 chk("mode", {7'h00, k != 3}, {7'h00, periph_mode_o});
      if (k > 0) begin
        rst_i = 1'b1;
        {strap_sda_i, strap_act_i} = 2'(k - 1);
        repeat (2) @(posedge clock_i);
        #1;
      end
    end
    $display("strap test done");
    // write both register pairs, read back, random wait
    for (int k = 0; k < 8; k++) begin
      d = $random(seed);
      stretch = $random(seed);
      xfer(4'd2, d, 2'd0);
      xfer(4'd3, ~d, 2'd0);
      xfer(4'd5, d + 8'h11, 2'd0);
      xfer(4'd5, d + 8'h22, 2'd1);
      xfer(4'd0, 8'h00, 2'd0);
      chk("data reg", d, r);
      xfer(4'd1, 8'h00, 2'd0);
      chk("address reg", ~d, r);
      xfer(4'd4, 8'h00, 2'd0);
      chk("mem reg 0", d + 8'h11, r);
      xfer(4'd4, 8'h00, 2'd1);
      chk("mem reg 1", d + 8'h22, r);
    end
    $display("strobe test done");
    // spi echo: all selects, bit orders, dual lanes
    for (int k = 0; k < 12; k++) begin
      d = $random(seed);
      req_lsb_first_i = k[0];
      req_last_i = k[1];
      xfer(k[2] ? 4'd9 : 4'd7, d, 2'(k / 4));
      chk("spi echo", d, r);
    end
    xfer(4'd8, d, 2'd0);
    span("three wire", 66);
    for (int k = 0; k < 4; k++) begin
      upper = 2'(k);
      d = $random(seed);
      xfer(4'd10, d, 2'd0);
      chk("bit stream", {upper, d[5:0] & 6'h37}, r);
    end
    $display("spi test done");
    // start, stop at each rate; byte write and read, no target
    for (int k = 0; k < 4; k++) begin
      i2c_rate_i = 2'(k);
      i2c_event_i = 2'd1;
      xfer(4'd6, 8'h00, 2'd0);
      span("i2c start", 4 * quarter(k) + 1);
      if (k == 3) begin
        i2c_event_i = 2'd0;
        xfer(4'd6, 8'ha0, 2'd0);
        span("i2c byte", 36 * quarter(k) + 1);
        chk("i2c nack", 8'h01, {7'h00, rsp_nack_o});
        i2c_read_i = 1'b1;
        xfer(4'd6, 8'h00, 2'd0);
        chk("i2c read", 8'hff, r);
        i2c_read_i = 1'b0;
      end
      i2c_event_i = 2'd2;
      xfer(4'd6, 8'h00, 2'd0);
      span("i2c stop", 4 * quarter(k) + 1);
    end
    $display("i2c test done");
    // interrupt edge latched, held, then cleared
    chk("irq idle", 8'h00, {7'h00, irq_pending_o});
    int_req_n_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1 int_req_n_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1 chk("irq set", 8'h01, {7'h00, irq_pending_o});
    irq_clear_i = 1'b1;
    @(posedge clock_i);
    #1 irq_clear_i = 1'b0;
    @(posedge clock_i);
    #1 chk("irq cleared", 8'h00, {7'h00, irq_pending_o});
    $display("irq test done");
    results();
  end
endmodule : tb_mpp_port
